// ### verilog/lvd_regs.svh
// Register indices, field positions, reset values and timing constants
`ifndef LVD_REGS_SVH
`define LVD_REGS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define LVD_IDX_CONTROL       16'hFFBE
`define LVD_IDX_THRESHOLD     16'hFFBF
`define LVD_IDX_CAUSE         16'hFFC0
`define LVD_IDX_STATUS        16'hFFC1

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LVD_CTL_CMP_EN_BIT    7
`define LVD_CTL_REF_EN_BIT    4
`define LVD_CTL_MODE_BIT      1
`define LVD_CTL_FLAG_BIT      0
`define LVD_THR_CODE_MSB      2
`define LVD_CAUSE_LVD_BIT     0
`define LVD_CAUSE_CLKMON_BIT  1
`define LVD_CAUSE_WDOG_BIT    4
`define LVD_STAT_REF_OK_BIT   0
`define LVD_STAT_CMP_OK_BIT   1
`define LVD_STAT_RAW_LOW_BIT  2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LVD_CONTROL_RESET     8'h00
`define LVD_THRESHOLD_RESET   3'h0
`define LVD_CAUSE_RESET       8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LVD_CLK_MHZ           50
`define LVD_T_REF_SETTLE_US   2000
`define LVD_T_CMP_SETTLE_US   200
`define LVD_RESET_HOLD        4
`define LVD_CNT_W             17

`endif

// ### verilog/lvd_pkg.sv
// Types shared by the low-voltage detect control block
package lvd_pkg;

    // ------------------------------------------------------------
    // Reset source of the current internal reset
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LVD_SRC_NONE,
        LVD_SRC_POWER_UP,
        LVD_SRC_SUPPLY_LOW,
        LVD_SRC_WATCHDOG,
        LVD_SRC_CLKMON
    } lvd_src_t;

    // ------------------------------------------------------------
    // Synchroniser state
    // ------------------------------------------------------------
    typedef struct packed {
        logic stage1;
        logic stage2;
    } lvd_sync_t;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    typedef struct packed {
        logic comparator_enable;
        logic reference_enable;
        logic reset_mode_select;
        logic supply_low_flag;
    } lvd_ctrl_t;

    // ------------------------------------------------------------
    // Whole state of the control block
    // ------------------------------------------------------------
    typedef struct packed {
        lvd_ctrl_t          ctrl;
        logic [2:0]         threshold_code;
        logic [7:0]         cause;
        logic               puc_fitted;
        logic [16:0]        ref_count;
        logic [16:0]        cmp_count;
        logic [2:0]         hold;
        lvd_src_t           src;
        logic               internal_reset;
        logic               ack;
        logic [7:0]         rdata;
    } lvd_state_t;

endpackage

// ### verilog/lvd_sync.sv
// Two-flop synchroniser for one comparator output
`timescale 1ns/1ps

module lvd_sync
    import lvd_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_async,
    output logic      o_sync
);

    lvd_sync_t state;
    lvd_sync_t next_state;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // First stage feeds only the second stage
    always_comb begin
        next_state        = state;
        next_state.stage1 = i_async;
        next_state.stage2 = state.stage1;
        if (i_reset) begin
            next_state = '0;
        end
    end

    // Register
    always_ff @(posedge i_clk) begin
        state <= next_state;
    end

    assign o_sync = state.stage2;

endmodule

// ### verilog/lvd_control.sv
// Low-voltage detect control: registers, flag, interrupt line, reset and reset cause
//
// Summary of operation
// - External reset clears control register
// - Control bits 7,4,1,0; others read zero
// - Comparator enable starts/stops detection
// - Reference enable; always on with power-up clear
// - Mode bit: zero interrupt, one reset
// - Flag reads supply low while enabled
// - Flag is read-only
// - Non-detector resets clear enable and mode bits
// - Irq line carries flag in interrupt mode
// - External reset clears threshold register
// - Three-bit code picks one of eight levels
// - Power-up clear beats detector response
// - Detector reset sets cause bit 0
// - Power-up clear zeroes cause register
// - Other resets set own cause flag
// - Power-up clear resets at ramp and brown-out
// - Detector keeps working in stop mode
// - No reset if supply already high
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "lvd_regs.svh"

module lvd_control
    import lvd_pkg::*;
#(
    parameter int unsigned REF_SETTLE_CYCLES = `LVD_T_REF_SETTLE_US * `LVD_CLK_MHZ,
    parameter int unsigned CMP_SETTLE_CYCLES = `LVD_T_CMP_SETTLE_US * `LVD_CLK_MHZ,
    parameter int unsigned RESET_HOLD        = `LVD_RESET_HOLD
)
(
    input  wire logic        i_clk,
    input  wire logic        i_reset,

    // Wishbone classic slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [17:0] i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,

    // Analog side
    input  wire logic        i_supply_low_cmp,
    input  wire logic        i_power_up_cmp,
    input  wire logic        i_puc_fitted,
    output logic             o_comparator_enable,
    output logic             o_reference_enable,
    output logic [2:0]       o_threshold_code,

    // Other reset sources, one-cycle requests
    input  wire logic        i_watchdog_reset_req,
    input  wire logic        i_clkmon_reset_req,

    // Results
    output logic             o_supply_low_irq,
    output logic             o_internal_reset,
    output logic [7:0]       o_reset_cause
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Largest settle count
    localparam int unsigned CNT_MAX = (1 << `LVD_CNT_W) - 1;

    generate
        if (REF_SETTLE_CYCLES < 1 || REF_SETTLE_CYCLES > CNT_MAX) begin : g_bad_ref
            $error("REF_SETTLE_CYCLES out of range");
        end

        if (CMP_SETTLE_CYCLES < 1 || CMP_SETTLE_CYCLES > CNT_MAX) begin : g_bad_cmp
            $error("CMP_SETTLE_CYCLES out of range");
        end

        // Stretch counter is 3 bits
        if (RESET_HOLD < 1 || RESET_HOLD > 7) begin : g_bad_hold
            $error("RESET_HOLD out of range");
        end
    endgenerate

    // Cut to counter width on purpose
    localparam logic [16:0] REF_LIMIT = REF_SETTLE_CYCLES[16:0];
    localparam logic [16:0] CMP_LIMIT = CMP_SETTLE_CYCLES[16:0];
    localparam logic [2:0]  HOLD_LOAD = RESET_HOLD[2:0];

    // ------------------------------------------------------------
    // Comparator synchronisers
    // ------------------------------------------------------------
    logic supply_low_sync;
    logic power_up_low_sync;

    // Both analog levels are asynchronous to the system clock
    lvd_sync u_sync_supply_low (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_supply_low_cmp),
        .o_sync  (supply_low_sync)
    );

    lvd_sync u_sync_power_up (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_power_up_cmp),
        .o_sync  (power_up_low_sync)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Whole block state
    lvd_state_t state;
    lvd_state_t next_state;

    // Bus terms
    logic        bus_req;
    logic        bus_write;

    logic [15:0] bus_index;
    logic        word_aligned;

    // Analog terms
    logic        ref_running;
    logic        ref_settled;
    logic        cmp_settled;
    logic        power_up_clear;
    logic        supply_low_reset;

    // Read views
    logic [7:0]  control_view;
    logic [7:0]  status_view;
    logic [7:0]  read_value;

    // Write strobes
    logic        ctrl_wr;
    logic        thr_wr;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // No new request in the ack cycle, so a request held until ack acts once; one held past ack acts again
    assign bus_req      = i_wb_cyc && i_wb_stb && !state.ack;
    assign bus_write    = bus_req && i_wb_we && i_wb_sel[0];

    assign bus_index    = i_wb_adr[17:2];
    assign word_aligned = (i_wb_adr[1:0] == 2'b00);

    assign ctrl_wr      = bus_write && word_aligned && (bus_index == `LVD_IDX_CONTROL);
    assign thr_wr       = bus_write && word_aligned && (bus_index == `LVD_IDX_THRESHOLD);

    // ------------------------------------------------------------
    // Analog-facing conditions
    // ------------------------------------------------------------
    // Reference always runs when power-up clear is fitted
    assign ref_running = state.ctrl.reference_enable || state.puc_fitted;

    // Status only; gates nothing
    assign ref_settled = (state.ref_count == REF_LIMIT);
    assign cmp_settled = (state.cmp_count == CMP_LIMIT);

    // Power-up clear acts only when fitted; it outranks the detector
    assign power_up_clear = state.puc_fitted && power_up_low_sync;

    // Level condition: a supply that is already high raises nothing
    assign supply_low_reset = state.ctrl.comparator_enable
                           && state.ctrl.reset_mode_select
                           && state.ctrl.supply_low_flag;

    // ------------------------------------------------------------
    // Read views
    // ------------------------------------------------------------
    // Unused control bits read as zero
    always_comb begin
        control_view                          = 8'h00;
        control_view[`LVD_CTL_CMP_EN_BIT]     = state.ctrl.comparator_enable;
        control_view[`LVD_CTL_REF_EN_BIT]     = state.ctrl.reference_enable;
        control_view[`LVD_CTL_MODE_BIT]       = state.ctrl.reset_mode_select;
        control_view[`LVD_CTL_FLAG_BIT]       = state.ctrl.supply_low_flag;
    end

    // Settling timers help software with its own waits
    always_comb begin
        status_view                           = 8'h00;
        status_view[`LVD_STAT_REF_OK_BIT]     = ref_settled;
        status_view[`LVD_STAT_CMP_OK_BIT]     = cmp_settled;
        status_view[`LVD_STAT_RAW_LOW_BIT]    = supply_low_sync;
    end

    // Address decode; unmapped indices read zero
    always_comb begin
        read_value = 8'h00;
        if (!word_aligned) begin
            read_value = 8'h00;
        end else if (bus_index == `LVD_IDX_CONTROL) begin
            read_value = control_view;
        end else if (bus_index == `LVD_IDX_THRESHOLD) begin
            read_value = {5'b00000, state.threshold_code};
        end else if (bus_index == `LVD_IDX_CAUSE) begin
            read_value = state.cause;
        end else if (bus_index == `LVD_IDX_STATUS) begin
            read_value = status_view;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // Bus answer: ack one cycle after the request, then drop
        next_state.ack = bus_req;

        if (bus_req) begin
            next_state.rdata = read_value;
        end

        // Software writes; the flag position is ignored
        if (ctrl_wr) begin
            next_state.ctrl.comparator_enable = i_wb_dat[`LVD_CTL_CMP_EN_BIT];
            next_state.ctrl.reference_enable  = i_wb_dat[`LVD_CTL_REF_EN_BIT];
            next_state.ctrl.reset_mode_select = i_wb_dat[`LVD_CTL_MODE_BIT];
        end

        // Bits 7..3 are dropped; software is told to write zeros there
        if (thr_wr) begin
            next_state.threshold_code = i_wb_dat[`LVD_THR_CODE_MSB:0];
        end

        // Flag follows the comparator only while detection is on
        next_state.ctrl.supply_low_flag =
            next_state.ctrl.comparator_enable && supply_low_sync;

        // Settling counters saturate; no stop-mode gating anywhere
        if (!ref_running) begin
            next_state.ref_count = '0;
        end else if (!ref_settled) begin
            next_state.ref_count = state.ref_count + 17'd1;
        end

        // Restarts whenever switched off
        if (!state.ctrl.comparator_enable) begin
            next_state.cmp_count = '0;
        end else if (!cmp_settled) begin
            next_state.cmp_count = state.cmp_count + 17'd1;
        end

        // Internal reset stretch counter
        if (state.hold != 3'd0) begin
            next_state.hold = state.hold - 3'd1;
        end

        // Reset sources, highest priority first
        if (power_up_clear) begin
            next_state.src            = LVD_SRC_POWER_UP;
            next_state.hold           = HOLD_LOAD;
            next_state.cause          = `LVD_CAUSE_RESET;
        end else if (supply_low_reset) begin
            next_state.src            = LVD_SRC_SUPPLY_LOW;
            next_state.hold           = HOLD_LOAD;
            next_state.cause[`LVD_CAUSE_LVD_BIT] = 1'b1;
        end else if (i_watchdog_reset_req) begin
            next_state.src            = LVD_SRC_WATCHDOG;
            next_state.hold           = HOLD_LOAD;
            next_state.cause[`LVD_CAUSE_WDOG_BIT] = 1'b1;
        end else if (i_clkmon_reset_req) begin
            next_state.src            = LVD_SRC_CLKMON;
            next_state.hold           = HOLD_LOAD;
            next_state.cause[`LVD_CAUSE_CLKMON_BIT] = 1'b1;
        end else if (state.hold == 3'd0) begin
            next_state.src            = LVD_SRC_NONE;
        end

        // A detector reset keeps its own settings; any other clears them
        if (power_up_clear || (!supply_low_reset
                && (i_watchdog_reset_req || i_clkmon_reset_req))) begin
            next_state.ctrl.comparator_enable = 1'b0;
            next_state.ctrl.reference_enable  = 1'b0;
            next_state.ctrl.reset_mode_select = 1'b0;
            // Flag goes with the enable
            next_state.ctrl.supply_low_flag   = 1'b0;
        end

        // Reset stays while the source persists and for the stretch after
        next_state.internal_reset = power_up_clear
                                 || supply_low_reset
                                 || i_watchdog_reset_req
                                 || i_clkmon_reset_req
                                 || (state.hold > 3'd1);

        // External reset: everything to its documented value
        if (i_reset) begin
            next_state.ctrl           = '0;
            next_state.threshold_code = `LVD_THRESHOLD_RESET;

            next_state.cause          = `LVD_CAUSE_RESET;

            // Strap captured only in reset
            next_state.puc_fitted     = i_puc_fitted;

            next_state.ref_count      = '0;
            next_state.cmp_count      = '0;
            next_state.hold           = '0;

            next_state.src            = LVD_SRC_NONE;
            next_state.internal_reset = 1'b0;

            next_state.ack            = 1'b0;
            next_state.rdata          = 8'h00;
        end
    end

    // Register
    always_ff @(posedge i_clk) begin
        state <= next_state;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_wb_ack            = state.ack;
    assign o_wb_dat            = {24'h000000, state.rdata};

    // Analog controls
    assign o_comparator_enable = state.ctrl.comparator_enable;
    assign o_reference_enable  = ref_running;
    assign o_threshold_code    = state.threshold_code;

    // Reset results
    assign o_internal_reset    = state.internal_reset;
    assign o_reset_cause       = state.cause;

    // Flag reaches the irq line only in interrupt mode
    assign o_supply_low_irq    = state.ctrl.supply_low_flag
                              && state.ctrl.comparator_enable
                              && !state.ctrl.reset_mode_select;

endmodule

// ### verilog/lvd_control_fix_note.sv
// Empty unit

// ### sim/lvd_control_assertions.sv
// Port-level assertions for the low-voltage detect control block
`timescale 1ns/1ps
`include "lvd_regs.svh"

module lvd_control_assertions (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [17:0] i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        i_supply_low_cmp,
    input wire logic        o_comparator_enable,
    input wire logic [2:0]  o_threshold_code,
    input wire logic        i_watchdog_reset_req,
    input wire logic        o_supply_low_irq,
    input wire logic        o_internal_reset,
    input wire logic [7:0]  o_reset_cause
);
    // ------------------------------------------------------------
    // Checks, all in the one clock domain
    // ------------------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // Bus answer one cycle after the request, as a single pulse
    property p_ack_lat; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("no ack after request");
    property p_ack_once; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");

    // Unused control bits and upper lanes must read zero
    property p_ctl_rd;
        o_wb_ack && !i_wb_we && i_wb_adr == {`LVD_IDX_CONTROL, 2'b00}
            |-> (o_wb_dat & 32'hFFFFFF6C) == 32'h00000000;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("reserved bits set");

    // Interrupt line only with the comparator running
    property p_irq_en; o_supply_low_irq |-> o_comparator_enable; endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq with comparator off");

    // Two sync stages plus the flag stage
    property p_irq_src; $rose(o_supply_low_irq) |-> $past(i_supply_low_cmp, 3); endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq without cause");

    // A detector reset keeps the enable set
    property p_keep; $rose(o_reset_cause[0]) |-> o_comparator_enable; endproperty
    a_keep: assert property (p_keep) else $error("enable lost");

    // Watchdog cause bit only follows a watchdog request
    property p_wd_cause;
        $rose(o_reset_cause[4]) |-> $past(i_watchdog_reset_req) || $past(i_watchdog_reset_req, 2);
    endproperty
    a_wd_cause: assert property (p_wd_cause) else $error("stray watchdog cause");
    property p_wd_rst; i_watchdog_reset_req |-> ##[1:2] o_internal_reset; endproperty
    a_wd_rst: assert property (p_wd_rst) else $error("watchdog request ignored");

    // Threshold moves only on a write
    property p_thr_wr;
        $changed(o_threshold_code) |-> $past(i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0]);
    endproperty
    a_thr_wr: assert property (p_thr_wr) else $error("stray threshold change");
endmodule

bind lvd_control lvd_control_assertions u_lvd_chk (.*);

// ### sim/lvd_analog_model.sv
// Behavioural model of the supply comparators and reference source
`timescale 1ns/1ps

module lvd_analog_model #(
    parameter logic [15:0] POWER_UP_MV = 16'h0B22
)(
    input  wire logic        i_comparator_enable,
    input  wire logic        i_reference_enable,
    input  wire logic [2:0]  i_threshold_code,
    input  wire logic [15:0] i_supply_mv,
    output logic             o_supply_low_cmp,
    output logic             o_power_up_cmp
);
    // Detection levels in millivolts, code 0 highest, code 7 lowest
    localparam logic [15:0] LEVEL_MV [8] = '{16'h10CC, 16'h1004, 16'h0F3C, 16'h0E74,
                                             16'h0DAC, 16'h0CE4, 16'h0C1C, 16'h0B22};

    // No settling delay: answers at once, the harshest timing for the flag path
    always_comb begin
        o_supply_low_cmp = i_comparator_enable && i_reference_enable &&
                           (i_supply_mv < LEVEL_MV[i_threshold_code]);
        o_power_up_cmp = i_supply_mv < POWER_UP_MV;
    end
endmodule

// ### sim/lvd_control_tb_top.sv
// Self-checking testbench for the low-voltage detect control block
`timescale 1ns/1ps
`include "lvd_regs.svh"

module lvd_control_tb_top;
    localparam logic [17:0] A_CTL = {`LVD_IDX_CONTROL, 2'b00};
    localparam logic [17:0] A_THR = {`LVD_IDX_THRESHOLD, 2'b00};
    localparam logic [17:0] A_CAU = {`LVD_IDX_CAUSE, 2'b00};
    logic        i_clk, i_reset, i_wb_cyc, i_wb_stb, i_wb_we, i_puc_fitted;
    logic        i_supply_low_cmp, i_power_up_cmp, i_watchdog_reset_req, i_clkmon_reset_req;
    logic        o_wb_ack, o_comparator_enable, o_reference_enable;
    logic        o_supply_low_irq, o_internal_reset;
    logic [2:0]  o_threshold_code;
    logic [3:0]  i_wb_sel;
    logic [7:0]  o_reset_cause;
    logic [15:0] supply_mv;
    logic [17:0] i_wb_adr;
    logic [31:0] i_wb_dat, o_wb_dat, rq;
    int          fail_count, check_count, cycles;

    lvd_control #(.REF_SETTLE_CYCLES(20), .CMP_SETTLE_CYCLES(10), .RESET_HOLD(4)) DUT (.*);

    lvd_analog_model u_analog (
        .i_comparator_enable(o_comparator_enable), .i_reference_enable(o_reference_enable),
        .i_threshold_code(o_threshold_code), .i_supply_mv(supply_mv),
        .o_supply_low_cmp(i_supply_low_cmp), .o_power_up_cmp(i_power_up_cmp)
    );

    // ------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // Whole sequence needs well under a thousand cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= w;
        i_wb_adr <= a;
        i_wb_dat <= {24'h000000, d};
        do @(posedge i_clk); while (o_wb_ack !== 1'b1);
        rq = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we  <= 1'b0;
    endtask

    task automatic rd(input logic [17:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(rq, {24'h000000, e});
    endtask

    // Bounded wait on the reset or irq line, then judge its level
    task automatic wait_for(input logic rst, input logic v);
        int n;
        n = 0;
        while ((rst ? o_internal_reset : o_supply_low_irq) !== v && n < 60) begin
            @(posedge i_clk);
            n++;
        end
        chk(rst ? o_internal_reset : o_supply_low_irq, v);
    endtask

    task automatic set_supply(input logic [15:0] v);
        @(posedge i_clk);
        supply_mv <= v;
    endtask

    task automatic do_reset(input logic strap);
        @(posedge i_clk);
        i_reset <= 1'b1;
        i_puc_fitted <= strap;
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
    endtask

    // One-cycle request, then ride out the reset
    task automatic pulse(input logic wdog);
        @(posedge i_clk);
        i_watchdog_reset_req <= wdog;
        i_clkmon_reset_req <= !wdog;
        @(posedge i_clk);
        i_watchdog_reset_req <= 1'b0;
        i_clkmon_reset_req <= 1'b0;
        wait_for(1'b1, 1'b1);
        wait_for(1'b1, 1'b0);
    endtask

    // Start-up order, waits scaled down
    task automatic start_detector(input logic mode);
        wb(1'b1, A_CTL, 8'h10);
        repeat (20) @(posedge i_clk);
        wb(1'b1, A_CTL, 8'h90);
        repeat (10) @(posedge i_clk);
        wb(1'b1, A_CTL, {6'h24, mode, 1'b0});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_vals();
        rd(A_CTL, 8'h00);
        rd(A_THR, 8'h00);
        rd(A_CAU, 8'h00);
        wb(1'b1, 18'h00000, 8'hFF);
        rd(18'h00000, 8'h00);
        chk(o_reference_enable, 1'b0);
    endtask

    task automatic t_fields();
        start_detector(1'b1);
        wb(1'b1, A_CTL, 8'hFF);
        rd(A_CTL, 8'h92);
        chk(o_internal_reset, 1'b0);
        chk(o_comparator_enable, 1'b1);
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, A_THR, {5'h00, c[2:0]});
            rd(A_THR, {5'h00, c[2:0]});
            chk(o_threshold_code, c[2:0]);
        end
        wb(1'b1, A_THR, 8'h00);
        wb(1'b1, A_CTL, 8'h00);
        rd(A_CTL, 8'h00);
        chk(o_comparator_enable, 1'b0);
    endtask

    task automatic t_irq();
        set_supply(16'h0FA0);
        start_detector(1'b0);
        wait_for(1'b0, 1'b1);
        rd(A_CTL, 8'h91);
        wb(1'b1, A_CTL, 8'h90);
        rd(A_CTL, 8'h91);
        chk(o_internal_reset, 1'b0);
        wb(1'b1, A_THR, 8'h02);
        wait_for(1'b0, 1'b0);
        rd(A_CTL, 8'h90);
        wb(1'b1, A_THR, 8'h00);
        wait_for(1'b0, 1'b1);
        wb(1'b1, A_CTL, 8'h10);
        wait_for(1'b0, 1'b0);
        rd(A_CTL, 8'h10);
        set_supply(16'h1194);
    endtask

    task automatic t_lvd_reset();
        start_detector(1'b1);
        repeat (6) @(posedge i_clk);
        chk(o_internal_reset, 1'b0);
        set_supply(16'h0FA0);
        wait_for(1'b1, 1'b1);
        chk(o_reset_cause, 8'h01);
        chk(o_comparator_enable, 1'b1);
        chk(o_supply_low_irq, 1'b0);
        set_supply(16'h1194);
        wait_for(1'b1, 1'b0);
        rd(A_CTL, 8'h92);
        rd(A_CAU, 8'h01);
        rd({`LVD_IDX_STATUS, 2'b00}, 8'h03);
    endtask

    task automatic t_other();
        pulse(1'b1);
        rd(A_CAU, 8'h11);
        rd(A_CTL, 8'h00);
        pulse(1'b0);
        rd(A_CAU, 8'h13);
    endtask

    // Power-up clear fitted; its comparator and code 7 trip together
    task automatic t_power_up();
        do_reset(1'b1);
        rd(A_CAU, 8'h00);
        chk(o_reference_enable, 1'b1);
        pulse(1'b1);
        wb(1'b1, A_THR, 8'h07);
        wb(1'b1, A_CTL, 8'h80);
        repeat (10) @(posedge i_clk);
        wb(1'b1, A_CTL, 8'h82);
        set_supply(16'h0A8C);
        wait_for(1'b1, 1'b1);
        chk(o_reset_cause, 8'h00);
        set_supply(16'h1194);
        wait_for(1'b1, 1'b0);
        rd(A_CAU, 8'h00);
        rd(A_CTL, 8'h00);
        rd(A_THR, 8'h07);
    endtask

    initial begin
        i_reset = 1'b1;
        i_wb_cyc = 1'b0;
        i_wb_stb = 1'b0;
        i_wb_we = 1'b0;
        i_wb_adr = 18'h00000;
        i_wb_sel = 4'h1;
        i_wb_dat = 32'h00000000;
        i_puc_fitted = 1'b0;
        i_watchdog_reset_req = 1'b0;
        i_clkmon_reset_req = 1'b0;
        supply_mv = 16'h1194;
        do_reset(1'b0);
        t_reset_vals();
        t_fields();
        t_irq();
        t_lvd_reset();
        t_other();
        t_power_up();
        stop_test();
    end
endmodule
